/* File: datapath_consts.vh */
// Constants for the ALU, shift unit, program counter and register file.
// Included by every design file of the datapath slice.
`ifndef DATAPATH_CONSTS_VH
`define DATAPATH_CONSTS_VH

// Microcode ALU operation codes
`define ALU_NOT_A 3'h0
`define ALU_PASS_B 3'h1
`define ALU_A_C 3'h2
`define ALU_A_B_C 3'h3
`define ALU_UNUSED 3'h4
`define ALU_A_A_C 3'h5
`define ALU_A_MINUS_B 3'h6
`define ALU_INSDEP 3'h7

// Shift unit input selects
`define SH_SWAP 2'h0
`define SH_PCB 2'h1
`define SH_PASS 2'h2
`define SH_RIGHT 2'h3

// Register address pad codes
`define PAD_AA 3'h0
`define PAD_AB 3'h1
`define PAD_CC 3'h2
`define PAD_UNUSED 3'h3
`define PAD_AA_PLUS 3'h4
`define PAD_BB 3'h5
`define PAD_OFF 3'h6
`define PAD_DD 3'h7

// Fixed register numbers
`define REG_FIVE 3'h5
`define REG_SP 3'h6
`define REG_SP_USER 3'h7
`define REG_PC 3'h7

// Status word bit positions
`define PSW_USER 15
`define PSW_NOT_KERNEL 14
`define PSW_SET 11

// Load codes of the second program counter stage
`define PCB_ALWAYS 2'h1
`define PCB_IF_SRC 2'h2
`define PCB_IF_DST 2'h3

// Source and destination mux selects
`define MX_SHIFT 2'h0
`define MX_REG 2'h1
`define MX_AUTO 2'h2

`define PC_RESET 16'h0000
`endif

/* File: shift_unit.v */
// Four-input shift unit: byte swap, program counter, pass, right shift.
// Assumes the caller supplies the right-shift inputs of bits 7 and 15.
`include "datapath_consts.vh"
module shift_unit (
	input wire [15:0] i_alu,
	input wire [15:0] i_pcb,
	input wire [1:0] i_sel,
	input wire i_bit7_in,
	input wire i_bit15_in,
	input wire i_bit7_pcb,
	output wire [15:0] o_data
);
	wire [15:0] right_in;
	wire [15:0] pcb_in;
	wire [15:0] swap_in;
	assign right_in = {i_bit15_in, i_alu[15:9], i_bit7_in, i_alu[7:1]};
	assign pcb_in = {i_pcb[15:8], i_bit7_pcb, i_pcb[6:0]};
	assign swap_in = {i_alu[7:0], i_alu[15:8]};
	genvar n;
	generate
		for (n = 0; n < 16; n = n + 1) begin : g_bit
			assign o_data[n] = (i_sel == `SH_SWAP) ? swap_in[n] :
				(i_sel == `SH_PCB) ? pcb_in[n] :
				(i_sel == `SH_PASS) ? i_alu[n] : right_in[n];
		end
	endgenerate
endmodule

/* File: gp_reg_file.v */
// Duplicated sixteen-entry general register file.
// Assumes write enables are active low and sampled on the rising clock.
`include "datapath_consts.vh"
module gp_reg_file (
	input wire i_clk,
	input wire [3:0] i_src_addr,
	input wire [3:0] i_dst_addr,
	input wire [15:0] i_wdata,
	input wire i_we_lo_n,
	input wire i_we_hi_n,
	output wire [15:0] o_src_data,
	output wire [15:0] o_dst_data
);
	reg [15:0] source_reg_copy [0:15];
	reg [15:0] dest_reg_copy [0:15];
	// Both copies take the write at the destination address
	always @(posedge i_clk) begin
		if (!i_we_lo_n) begin
			source_reg_copy[i_dst_addr][7:0] <= i_wdata[7:0];
			dest_reg_copy[i_dst_addr][7:0] <= i_wdata[7:0];
		end
		if (!i_we_hi_n) begin
			source_reg_copy[i_dst_addr][15:8] <= i_wdata[15:8];
			dest_reg_copy[i_dst_addr][15:8] <= i_wdata[15:8];
		end
	end
	assign o_src_data = source_reg_copy[i_src_addr];
	assign o_dst_data = dest_reg_copy[i_dst_addr];
endmodule

/* File: alu_datapath.v */
// ALU control and function, shift unit control, zero detection,
// two-stage program counter and general register addressing.
// Assumes the decode logic supplies instruction flags and lookup outputs,
// and that the timing pulses are one clock wide.
`include "datapath_consts.vh"
// Operation
// - 3-bit op field gives six control signals
// - Fixed codes: B, A+C, A+B+C, 2A+C, A-B
// - Two-word left shift: carry from low word MSB
// - Carry insert from C for ADC/ROTATE_LEFT_INSTR, from inverted C for SUBTRACT_CARRY_INSTR
// - Byte move to register sign-extends high byte
// - Shifter picks swap, PC B, pass, right
// - Swap exchanges ALU bytes into shifter outputs
// - Left shift done in ALU as A+A
// - Arithmetic right shifts replicate ALU bit 15
// - Rotate right and multiply inject special top bit
// - Multiply top bit from source sign and cycle
// - Bit 7 right input: ALU8, ALU7 or C
// - Zero test covers word, low or high byte
// - Two-word check only clears Z
// - Shift select follows lookup, forced zero cases
// - PC stage A loads ALU at T5
// - PC stage B loads stage A at T1
// - Specifier 7 is PC, 6 is mode SP
// - Specifiers 0-5 select set by PSW bit 11
// - Two copies, common write address
// - Register 7 source routes PC B via shifter
// - Pad field picks address sources, 6 zeroes
// - Separate active-low byte write enables
module alu_datapath (
	input wire i_clk,
	input wire i_sys_rst,
	input wire i_t1,
	input wire i_t5,
	input wire [2:0] i_alu_op_field,
	input wire [3:0] i_lookup_sel,
	input wire i_lookup_mode_out,
	input wire i_lookup_carry_out,
	input wire [1:0] i_lookup_shift_sel,
	input wire [1:0] i_shift_sel_field,
	input wire [15:0] i_a,
	input wire [15:0] i_b,
	input wire i_low_word_msb,
	input wire i_c_flag,
	input wire i_z_flag,
	input wire i_combined_arith_shift_instr,
	input wire i_divide_instr,
	input wire i_add_carry_instr,
	input wire i_rotate_left_instr,
	input wire i_subtract_carry_instr,
	input wire i_byte_move_instr,
	input wire i_arith_right_instr,
	input wire i_arith_right_byte_instr,
	input wire i_rotate_right_instr,
	input wire i_rotate_right_byte_instr,
	input wire i_negate_instr,
	input wire i_negate_byte_instr,
	input wire i_byte_swap_instr,
	input wire i_multiply_instr,
	input wire i_class_i,
	input wire i_src_positive,
	input wire i_src_negative,
	input wire i_byte_data,
	input wire i_odd_byte,
	input wire i_dest_is_reg,
	input wire [2:0] i_dest_mode,
	input wire i_two_word_zero_check,
	input wire i_pca_load,
	input wire [1:0] i_pcb_load_code,
	input wire i_conditional_write_bit,
	input wire [2:0] i_src_field,
	input wire [2:0] i_dst_field,
	input wire i_plus_one,
	input wire [2:0] i_pad_field,
	input wire [15:0] i_processor_status_word,
	input wire [1:0] i_src_mux_sel,
	input wire [1:0] i_dst_mux_sel,
	input wire i_low_byte_write_enable_n,
	input wire i_high_byte_write_enable_n,
	output reg [15:0] o_shift_data,
	output reg o_zero,
	output reg o_z_next,
	output reg o_carry_out,
	output reg [15:0] o_pc_stage_a,
	output reg [15:0] o_pc_stage_b,
	output reg [15:0] o_src_mux,
	output reg [15:0] o_dst_mux
);
	reg [3:0] alu_s;
	reg alu_m;
	reg alu_c;
	reg [16:0] sum;
	reg [15:0] alu_out;
	reg [1:0] shift_sel;
	reg [2:0] src_addr;
	reg [2:0] dst_addr;
	reg src_set;
	reg dst_set;
	wire insdep;
	wire carry_dep;
	wire user_mode;
	wire not_kernel;
	wire shift_unit_data;
	wire bit15_in;
	wire bit7_in;
	wire bit7_pcb;
	wire [15:0] shift_out;
	wire [15:0] gs_data;
	wire [15:0] gd_data;
	wire lo_zero;
	wire hi_zero;
	wire next_zero;
	wire force_zero_sel;
	wire src_pc;
	wire dst_pc;
	reg pcb_load;

	assign insdep = (i_alu_op_field == `ALU_INSDEP);
	assign carry_dep = i_lookup_mode_out & i_lookup_carry_out;
	assign user_mode = i_processor_status_word[`PSW_USER];
	assign not_kernel = i_processor_status_word[`PSW_NOT_KERNEL];

	// ALU control decode; S bits, mode and carry in
	always @* begin
		alu_s = 4'h0;
		alu_m = 1'b1;
		alu_c = 1'b0;
		case (i_alu_op_field)
		`ALU_NOT_A: begin
			alu_s = 4'h0;
			alu_m = 1'b1;
		end
		`ALU_PASS_B: begin
			alu_s = 4'hA;
			alu_m = 1'b1;
		end
		`ALU_A_C: begin
			alu_s = 4'h0;
			alu_m = 1'b0;
		end
		`ALU_A_B_C: begin
			alu_s = 4'h9;
			alu_m = 1'b0;
		end
		`ALU_A_A_C: begin
			alu_s = 4'hC;
			alu_m = 1'b0;
		end
		`ALU_A_MINUS_B: begin
			alu_s = 4'h6;
			alu_m = 1'b0;
			alu_c = 1'b1;
		end
		`ALU_INSDEP: begin
			alu_s = i_lookup_sel;
			if (i_byte_swap_instr) begin
				alu_s[3:2] = 2'h3;
			end
			alu_m = i_lookup_mode_out & ~carry_dep;
			if (i_combined_arith_shift_instr | i_divide_instr) begin
				alu_c = i_low_word_msb;
			end else if (carry_dep) begin
				alu_c = ((i_add_carry_instr | i_rotate_left_instr) &
					i_c_flag) | (i_subtract_carry_instr & ~i_c_flag);
			end
		end
		default: begin
			alu_s = 4'h0;
			alu_m = 1'b1;
		end
		endcase
	end

	// ALU function for the select patterns this datapath uses
	always @* begin
		sum = {1'b0, i_a};
		if (alu_m) begin
			case (alu_s)
			4'h0: sum = {1'b0, ~i_a};
			4'hA: sum = {1'b0, i_b};
			4'h3: sum = 17'h00000;
			default: sum = {1'b0, i_a};
			endcase
		end else begin
			case (alu_s)
			4'h0: sum = {1'b0, i_a} + {16'h0000, alu_c};
			4'h9: sum = {1'b0, i_a} + {1'b0, i_b} + {16'h0000, alu_c};
			4'hC: sum = {1'b0, i_a} + {1'b0, i_a} + {16'h0000, alu_c};
			4'h6: sum = {1'b0, i_a} + {1'b0, ~i_b} + {16'h0000, alu_c};
			4'h3: sum = 17'h0FFFF + {16'h0000, alu_c};
			default: sum = {1'b0, i_a};
			endcase
		end
		alu_out = sum[15:0];
		if (i_byte_move_instr & i_dest_is_reg) begin
			alu_out[15:8] = {8{sum[7]}};
		end
	end

	// Special top bit for rotate right and multiply
	assign shift_unit_data = i_multiply_instr ?
		(i_class_i & ((insdep & i_src_positive) |
		(~insdep & i_src_negative))) :
		i_c_flag;
	assign bit15_in = (i_rotate_right_instr | i_rotate_right_byte_instr |
		i_multiply_instr) ? shift_unit_data : sum[15];
	assign bit7_in = i_byte_data ? sum[7] : sum[8];
	assign bit7_pcb = i_rotate_right_byte_instr ? i_c_flag :
		o_pc_stage_b[7];

	assign force_zero_sel = i_byte_swap_instr |
		((i_arith_right_byte_instr | i_rotate_right_byte_instr |
		i_negate_instr | i_negate_byte_instr) &
		(i_dest_mode != 3'h0));
	assign src_pc = (i_src_field == `REG_PC);
	assign dst_pc = (i_dst_field == `REG_PC);

	// Shift select: lookup when instruction dependent, microcode otherwise except PC B when an auto mux routes register 7
	always @* begin
		shift_sel = i_shift_sel_field;
		if (insdep) begin
			if (force_zero_sel) begin
				shift_sel = `SH_SWAP;
			end else if (i_rotate_right_byte_instr) begin
				shift_sel = `SH_PCB;
			end else if (i_byte_data &
				(i_lookup_shift_sel == `SH_RIGHT)) begin
				shift_sel = `SH_PASS;
			end else begin
				shift_sel = i_lookup_shift_sel;
			end
		end else if ((i_src_mux_sel == `MX_AUTO && src_pc) ||
			(i_dst_mux_sel == `MX_AUTO && dst_pc)) begin
			shift_sel = `SH_PCB;
		end
	end

	shift_unit u_shift (
		.i_alu(alu_out),
		.i_pcb(o_pc_stage_b),
		.i_sel(shift_sel),
		.i_bit7_in(bit7_in),
		.i_bit15_in(bit15_in),
		.i_bit7_pcb(bit7_pcb),
		.o_data(shift_out)
	);

	assign lo_zero = (shift_out[7:0] == 8'h00);
	assign hi_zero = (shift_out[15:8] == 8'h00);
	assign next_zero = (i_odd_byte | i_byte_swap_instr) ? hi_zero :
		(i_byte_data ? lo_zero : (lo_zero & hi_zero));

	// Register address mux and set select
	always @* begin
		src_addr = i_src_field;
		dst_addr = i_dst_field;
		if (i_src_field == `REG_SP) begin
			src_addr[0] = user_mode;
		end
		if (i_pad_field == `PAD_AA_PLUS) begin
			src_addr[0] = src_addr[0] | i_plus_one;
		end
		if (i_dst_field == `REG_SP) begin
			dst_addr[0] = user_mode;
		end
		src_set = (i_src_field == `REG_SP) ? not_kernel :
			i_processor_status_word[`PSW_SET];
		dst_set = (i_dst_field == `REG_SP) ? not_kernel :
			i_processor_status_word[`PSW_SET];
		case (i_pad_field)
		`PAD_AA, `PAD_AA_PLUS: begin
			dst_addr = src_addr;
			dst_set = src_set;
		end
		`PAD_AB: begin
		end
		`PAD_BB: begin
			src_addr = dst_addr;
			src_set = dst_set;
		end
		`PAD_CC: begin
			src_addr = `REG_FIVE;
			dst_addr = `REG_FIVE;
			src_set = i_processor_status_word[`PSW_SET];
			dst_set = src_set;
		end
		`PAD_DD: begin
			src_addr = user_mode ? `REG_SP_USER : `REG_SP;
			dst_addr = src_addr;
			src_set = not_kernel;
			dst_set = not_kernel;
		end
		`PAD_OFF: begin
			src_addr = 3'h0;
			dst_addr = 3'h0;
			src_set = i_processor_status_word[`PSW_SET];
			dst_set = src_set;
		end
		default: begin
			src_addr = 3'h0;
			dst_addr = 3'h0;
			src_set = 1'b0;
			dst_set = 1'b0;
		end
		endcase
	end

	gp_reg_file u_regs (
		.i_clk(i_clk),
		.i_src_addr({src_set, src_addr}),
		.i_dst_addr({dst_set, dst_addr}),
		.i_wdata(shift_out),
		.i_we_lo_n(i_low_byte_write_enable_n),
		.i_we_hi_n(i_high_byte_write_enable_n),
		.o_src_data(gs_data),
		.o_dst_data(gd_data)
	);

	// Conditional load of stage B
	always @* begin
		case (i_pcb_load_code)
		`PCB_ALWAYS: pcb_load = 1'b1;
		`PCB_IF_SRC: pcb_load = src_pc;
		`PCB_IF_DST: pcb_load = dst_pc &
			~(i_class_i & i_conditional_write_bit);
		default: pcb_load = 1'b0;
		endcase
	end

	always @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_pc_stage_a <= `PC_RESET;
			o_pc_stage_b <= `PC_RESET;
			o_shift_data <= 16'h0000;
			o_zero <= 1'b0;
			o_z_next <= 1'b0;
			o_carry_out <= 1'b0;
			o_src_mux <= 16'h0000;
			o_dst_mux <= 16'h0000;
		end else begin
			if (i_t5 & i_pca_load) begin
				o_pc_stage_a <= alu_out;
			end
			if (i_t1 & pcb_load) begin
				o_pc_stage_b <= o_pc_stage_a;
			end
			o_shift_data <= shift_out;
			o_zero <= next_zero;
			o_z_next <= i_two_word_zero_check ?
				(i_z_flag & next_zero) : next_zero;
			o_carry_out <= i_byte_data ? (sum[8] ^ i_a[8] ^ i_b[8]) :
				sum[16];
			o_src_mux <= (i_src_mux_sel == `MX_REG ||
				(i_src_mux_sel == `MX_AUTO && !src_pc)) ?
				gs_data : shift_out;
			o_dst_mux <= (i_dst_mux_sel == `MX_REG ||
				(i_dst_mux_sel == `MX_AUTO && !dst_pc)) ?
				gd_data : shift_out;
		end
	end
endmodule

/* File: alu_datapath_asserts.sv */
// Port checks for the datapath slice: program counter stages, shift unit.
// Bound into alu_datapath; one clock, asynchronous active-high reset.
`include "datapath_consts.vh"
module alu_datapath_asserts (
	input wire i_clk,
	input wire i_sys_rst,
	input wire i_t1,
	input wire i_t5,
	input wire i_pca_load,
	input wire [1:0] i_pcb_load_code,
	input wire [2:0] i_src_field,
	input wire [2:0] i_dst_field,
	input wire i_class_i,
	input wire i_conditional_write_bit,
	input wire [2:0] i_alu_op_field,
	input wire [1:0] i_shift_sel_field,
	input wire [15:0] i_b,
	input wire i_byte_data,
	input wire i_byte_move_instr,
	input wire i_byte_swap_instr,
	input wire i_rotate_right_instr,
	input wire i_rotate_right_byte_instr,
	input wire i_multiply_instr,
	input wire [1:0] i_src_mux_sel,
	input wire [1:0] i_dst_mux_sel,
	input wire [15:0] o_shift_data,
	input wire [15:0] o_pc_stage_a,
	input wire [15:0] o_pc_stage_b
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst);
	// Word pass of operand B with no byte or auto-routing override
	wire pass_b = i_alu_op_field == `ALU_PASS_B && !i_byte_data &&
		!i_byte_move_instr && !i_byte_swap_instr &&
		!i_rotate_right_byte_instr && i_src_mux_sel != `MX_AUTO &&
		i_dst_mux_sel != `MX_AUTO;
	wire pcb_skip = i_pcb_load_code == 2'h0 ||
		(i_pcb_load_code == `PCB_IF_SRC && i_src_field != `REG_PC) ||
		(i_pcb_load_code == `PCB_IF_DST && (i_dst_field != `REG_PC ||
		i_class_i && i_conditional_write_bit));
	sequence s_pca_take;
		i_t5 && i_pca_load;
	endsequence
	sequence s_shift(logic [1:0] sel);
		pass_b && i_shift_sel_field == sel;
	endsequence
	a_pca_take: assert property (
		s_pca_take ##0 pass_b |=> o_pc_stage_a == $past(i_b))
		else $error("stage a missed load");
	a_pca_hold: assert property (
		!(i_t5 && i_pca_load) |=> $stable(o_pc_stage_a))
		else $error("stage a changed");
	a_pcb_take: assert property (
		i_t1 && i_pcb_load_code == `PCB_ALWAYS |=>
		o_pc_stage_b == $past(o_pc_stage_a))
		else $error("stage b missed load");
	a_pcb_hold: assert property (
		!i_t1 || pcb_skip |=> $stable(o_pc_stage_b))
		else $error("stage b changed");
	a_shift_pass: assert property (
		s_shift(`SH_PASS) |=> o_shift_data == $past(i_b))
		else $error("pass input wrong");
	a_shift_swap: assert property (
		s_shift(`SH_SWAP) |=>
		o_shift_data == {$past(i_b[7:0]), $past(i_b[15:8])})
		else $error("byte swap wrong");
	a_shift_pcb: assert property (
		s_shift(`SH_PCB) |=> o_shift_data == $past(o_pc_stage_b))
		else $error("pc input wrong");
	a_shift_right: assert property (
		s_shift(`SH_RIGHT) ##0 !i_rotate_right_instr && !i_multiply_instr
		|=> o_shift_data == {$past(i_b[15]), $past(i_b[15:1])})
		else $error("right shift wrong");
endmodule
bind alu_datapath alu_datapath_asserts u_alu_datapath_asserts (.*);

/* File: decode_model.sv */
// Decode model: one-hot instruction flags from an instruction kind.
// Combinational like the decode lookup; kinds 0 and 15 raise no flag.
module decode_model (
	input wire logic [3:0] i_kind,
	input wire logic i_class,
	output logic [14:0] o_flags
);
	timeunit 1ns;
	timeprecision 1ps;
	always_comb begin
		o_flags = {14'h0000, i_class};
		if (i_kind != 4'h0 && i_kind != 4'hF)
			o_flags[4'hF - i_kind] = 1'h1;
	end
endmodule

/* File: alu_datapath_tb.sv */
// Self-checking bench for alu_datapath beside a decode model.
// Stands alone; inputs change by non-blocking assignment at rising edges.
`include "datapath_consts.vh"
module alu_datapath_tb;
	timeunit 1ns;
	timeprecision 1ps;
	bit i_clk, i_t1, i_t5, i_pca_load, i_plus_one, i_lookup_mode_out;
	bit i_lookup_carry_out, i_low_word_msb, i_c_flag, i_z_flag, i_odd_byte;
	bit i_src_positive, i_src_negative, i_byte_data, i_dest_is_reg, cls, ld;
	bit i_two_word_zero_check, i_conditional_write_bit, i_sys_rst = 1'h1;
	bit i_low_byte_write_enable_n = 1'h1, i_high_byte_write_enable_n = 1'h1;
	bit [1:0] i_lookup_shift_sel, i_shift_sel_field, i_pcb_load_code;
	bit [1:0] i_src_mux_sel, i_dst_mux_sel;
	bit [2:0] i_alu_op_field, i_dest_mode, i_src_field, i_dst_field;
	bit [2:0] i_pad_field;
	bit [3:0] i_lookup_sel, kind;
	bit [15:0] i_a, i_b, i_processor_status_word, v;
	logic i_combined_arith_shift_instr, i_divide_instr, i_add_carry_instr;
	logic i_rotate_left_instr, i_subtract_carry_instr, i_byte_move_instr;
	logic i_arith_right_instr, i_arith_right_byte_instr, i_negate_instr;
	logic i_rotate_right_instr, i_rotate_right_byte_instr, i_byte_swap_instr;
	logic i_negate_byte_instr, i_multiply_instr, i_class_i, o_zero;
	logic o_z_next, o_carry_out;
	logic [15:0] o_shift_data, o_pc_stage_a, o_pc_stage_b, o_src_mux;
	logic [15:0] o_dst_mux, exp_a, exp_b, r;
	logic [15:0] d [7];
	int err_total, n_tests, cycles;

	alu_datapath u_alu_datapath (.*);
	decode_model u_decode_model (
		.i_kind(kind),
		.i_class(cls),
		.o_flags({i_combined_arith_shift_instr, i_divide_instr,
			i_add_carry_instr, i_rotate_left_instr, i_subtract_carry_instr,
			i_byte_move_instr, i_arith_right_instr, i_arith_right_byte_instr,
			i_rotate_right_instr, i_rotate_right_byte_instr, i_negate_instr,
			i_negate_byte_instr, i_byte_swap_instr, i_multiply_instr,
			i_class_i})
	);

	always #4 i_clk = ~i_clk;

	function automatic logic [15:0] alu(input logic [2:0] op,
		input logic [15:0] a, input logic [15:0] b);
		case (op)
			`ALU_PASS_B: return b;
			`ALU_A_C: return a;
			`ALU_A_B_C: return a + b;
			`ALU_A_A_C: return a + a;
			`ALU_A_MINUS_B: return a - b;
			default: return ~a;
		endcase
	endfunction

	// Rotate kind puts the carry flag into the top bit on a right shift
	function automatic logic [15:0] shf(input logic [1:0] s,
		input logic [15:0] x);
		case (s)
			`SH_SWAP: return {x[7:0], x[15:8]};
			`SH_PCB: return exp_b;
			`SH_PASS: return x;
			default: return {kind == 4'h9 ? i_c_flag : x[15], x[15:1]};
		endcase
	endfunction

	// Carry out of bit 15 for the fixed operations; logic modes give none
	function automatic logic cy(input logic [2:0] op,
		input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		case (op)
			`ALU_A_B_C: s = a + b;
			`ALU_A_A_C: s = a + a;
			`ALU_A_MINUS_B: s = a + {1'b0, ~b} + 17'h00001;
			default: s = 17'h00000;
		endcase
		return s[16];
	endfunction

	function automatic logic pcb_load();
		case (i_pcb_load_code)
			`PCB_ALWAYS: return 1'h1;
			`PCB_IF_SRC: return i_src_field == `REG_PC;
			`PCB_IF_DST: return i_dst_field == `REG_PC &&
				!(cls && i_conditional_write_bit);
			default: return 1'h0;
		endcase
	endfunction

	task automatic cmp(input logic [15:0] got, input logic [15:0] want);
		n_tests++;
		if (got !== want) begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, got, want);
		end
	endtask

	task automatic wrap_up();
		if (err_total == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Write enables are active low: bit 1 low byte, bit 0 high byte
	task automatic wr(input logic [2:0] f, input logic [15:0] p,
		input logic [2:0] pad, input logic [1:0] we, input logic [15:0] x);
		@(posedge i_clk);
		{i_alu_op_field, i_shift_sel_field, i_b} <= {`ALU_PASS_B, `SH_PASS, x};
		{i_dst_field, i_processor_status_word, i_pad_field} <= {f, p, pad};
		{i_low_byte_write_enable_n, i_high_byte_write_enable_n} <= we;
		{i_src_mux_sel, i_dst_mux_sel, kind} <= 8'h00;
		@(posedge i_clk);
		{i_low_byte_write_enable_n, i_high_byte_write_enable_n} <= 2'h3;
	endtask

	task automatic rd(input logic [2:0] f, input logic [15:0] p,
		input logic [1:0] mx, input logic [15:0] x);
		@(posedge i_clk);
		{i_src_field, i_dst_field, i_pad_field} <= {f, f, `PAD_BB};
		{i_processor_status_word, i_src_mux_sel, i_dst_mux_sel} <= {p, mx, mx};
		@(posedge i_clk);
		#1;
		cmp(o_src_mux, x);
		cmp(o_dst_mux, x);
	endtask

	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			err_total++;
			wrap_up();
		end
	end

	initial begin
		void'($urandom(74));
		repeat (20) @(posedge i_clk);
		i_sys_rst <= 1'h0;
		exp_a = `PC_RESET;
		exp_b = `PC_RESET;
		#1;
		cmp(o_pc_stage_b, exp_b);
		for (int k = 0; k < 40; k++) begin
			v = $urandom;
			ld = 1'($urandom);
			@(posedge i_clk);
			{i_t5, i_pca_load, i_alu_op_field, i_b} <= {1'h1, ld, `ALU_PASS_B, v};
			@(posedge i_clk);
			{i_t5, i_t1, i_pcb_load_code} <= {2'h1, 2'($urandom)};
			i_src_field <= $urandom_range(1, 0) ? `REG_PC : 3'h2;
			i_dst_field <= $urandom_range(1, 0) ? `REG_PC : 3'h4;
			{cls, i_conditional_write_bit} <= 2'($urandom);
			@(posedge i_clk);
			if (ld)
				exp_a = v;
			if (pcb_load())
				exp_b = exp_a;
			i_t1 <= 1'h0;
			#1;
			cmp(o_pc_stage_a, exp_a);
			cmp(o_pc_stage_b, exp_b);
		end
		for (int k = 0; k < 300; k++) begin
			v = $urandom;
			@(posedge i_clk);
			i_a <= v;
			i_b <= (k % 5 == 0) ? v : 16'($urandom);
			i_alu_op_field <= 3'($urandom_range(6, 0));
			i_shift_sel_field <= 2'($urandom);
			i_c_flag <= 1'($urandom);
			{i_z_flag, i_two_word_zero_check} <= 2'($urandom);
			kind <= $urandom_range(1, 0) ? 4'h9 : 4'h0;
			@(posedge i_clk);
			#1;
			r = shf(i_shift_sel_field, alu(i_alu_op_field, i_a, i_b));
			cmp(o_shift_data, r);
			cmp({15'h0000, o_zero}, {15'h0000, r == 16'h0000});
			cmp({15'h0000, o_z_next}, {15'h0000, i_two_word_zero_check ?
				(i_z_flag && r == 16'h0000) : r == 16'h0000});
			cmp({15'h0000, o_carry_out},
				{15'h0000, cy(i_alu_op_field, i_a, i_b)});
		end
		// Instruction-dependent cycles: carry modifications, forced swap
		for (int k = 0; k < 40; k++) begin
			v = $urandom;
			@(posedge i_clk);
			kind <= (k % 4 == 3) ? 4'hB : 4'(2 * (k % 4) + 1);
			i_a <= v;
			i_alu_op_field <= `ALU_INSDEP;
			i_lookup_sel <= 4'h0;
			i_lookup_shift_sel <= `SH_PASS;
			{i_lookup_mode_out, i_lookup_carry_out} <=
				(k % 4 == 1 || k % 4 == 2) ? 2'h3 : 2'h0;
			{i_c_flag, i_low_word_msb} <= 2'($urandom);
			i_dest_mode <= 3'($urandom_range(7, 1));
			@(posedge i_clk);
			#1;
			r = i_a + 16'(kind == 4'h1 ? i_low_word_msb :
				kind == 4'h3 ? i_c_flag : kind == 4'h5 ? !i_c_flag : 1'h0);
			if (kind == 4'hB)
				r = {r[7:0], r[15:8]};
			cmp(o_shift_data, r);
		end
		for (int k = 0; k < 7; k++)
			d[k] = $urandom;
		wr(3'h3, 16'h0000, `PAD_BB, 2'h0, d[0]);
		wr(3'h3, 16'h0800, `PAD_BB, 2'h0, d[1]);
		wr(`REG_SP, 16'h0000, `PAD_BB, 2'h0, d[2]);
		wr(`REG_SP, 16'h4000, `PAD_BB, 2'h0, d[3]);
		wr(`REG_SP, 16'hC000, `PAD_BB, 2'h0, d[4]);
		wr(3'h3, 16'h0000, `PAD_BB, 2'h1, d[5]);
		wr(3'h3, 16'h0000, `PAD_OFF, 2'h0, d[6]);
		rd(3'h3, 16'h0000, `MX_REG, {d[0][15:8], d[5][7:0]});
		rd(3'h3, 16'h0800, `MX_REG, d[1]);
		rd(`REG_SP, 16'h0000, `MX_REG, d[2]);
		rd(`REG_SP, 16'h4000, `MX_REG, d[3]);
		rd(`REG_SP, 16'hC000, `MX_REG, d[4]);
		rd(3'h0, 16'h0000, `MX_REG, d[6]);
		rd(`REG_PC, 16'h0000, `MX_AUTO, exp_b);
		wrap_up();
	end
endmodule
